// ### inc/tsd_consts.svh
// Purpose: Shared constants of the touch digitizer command and pen logic
// Assumes: Included by bare name from package and design files
// Notes:   Definitions only
`ifndef TSD_CONSTS_SVH
`define TSD_CONSTS_SVH

// ****************************************
// Command word layout
// ****************************************
`define TSD_WORD_BITS 8
`define TSD_BIT_START 7
`define TSD_CH_HI     6
`define TSD_CH_LO     4
`define TSD_BIT_RES   3
`define TSD_BIT_REF   2
`define TSD_BIT_PDH   1
`define TSD_BIT_PDL   0

// ****************************************
// Reset values
// ****************************************
`define TSD_WORD_RST  8'h02
`define TSD_PEN_RST   1'b1

// ****************************************
// Serial clock counts and battery channel code
// ****************************************
`define TSD_FRAME_12  4'hf
`define TSD_FRAME_8   4'hb
`define TSD_REL_FALL  4'h4
`define TSD_CH_DONE   4'h3
`define TSD_WORD_DONE 4'h7
`define TSD_BAT_CH    3'h2

`endif

// ### inc/tsd_pkg.sv
// Purpose: Types shared by the touch digitizer command and pen logic
// Assumes: tsd_consts.svh on the include path
// Notes:   Types only; numbers live in the header
`include "tsd_consts.svh"

package tsd_pkg;

    // Serial link frame states
    typedef enum logic [1:0] {
        LS_IDLE,
        LS_CMD,
        LS_CONV
    } tsd_link_state_t;

    // One command word
    typedef logic [`TSD_WORD_BITS-1:0] tsd_word_t;

endpackage

// ### hw/tsd_cmd_shift.sv
// Purpose: Serial command capture on the serial bit clock
// Assumes: Host drives cmd_din, stable around rising serial clock edges
// Notes:   Events leave as toggles; the word holds until the next word
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.svh"

module tsd_cmd_shift import tsd_pkg::*; #(
    parameter logic [2:0] BAT_CHANNEL = `TSD_BAT_CH
) (
    // Link clock and core reset
    input  wire logic      serial_bit_clock,
    input  wire logic      rst_n,
    // Serial command input
    input  wire logic      cmd_din,
    // Events and levels toward the core
    output logic           start_tgl,
    output logic           release_tgl,
    output logic           word_tgl,
    output logic           done_tgl,
    output tsd_word_t      cmd_word,
    output logic           batt_sample,
    output logic           conv_busy
);

    // ****************************************
    // Reset brought onto the link clock
    // ****************************************
    logic            lrst1_q;
    logic            lrst2_q;
    tsd_link_state_t state_q, state_d;
    logic [3:0]      cnt_q, cnt_d;
    logic [5:0]      sreg_q, sreg_d;
    tsd_word_t       word_q, word_d;
    logic            start_q, start_d;
    logic            wtgl_q, wtgl_d;
    logic            done_q, done_d;
    logic            batt_q, batt_d;
    logic            busy_q, busy_d;
    logic            rel_q, rel_d;
    logic [3:0]      frame_last;

    // Two stages; link clock may stop so reset is seen only when it runs
    always_ff @(posedge serial_bit_clock) begin
        lrst1_q <= rst_n;
        lrst2_q <= lrst1_q;
    end

    // ****************************************
    // Frame sequencer, rising edge sampling
    // ****************************************
    // Frame length follows the resolution of the word in flight
    assign frame_last = (word_q[`TSD_BIT_RES] ? `TSD_FRAME_8 : `TSD_FRAME_12) - 4'h1; // [R20]

    // Next state of the frame
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sreg_d  = sreg_q;
        word_d  = word_q;
        start_d = start_q;
        wtgl_d  = wtgl_q;
        done_d  = done_q;
        batt_d  = batt_q;
        case (state_q)
            LS_IDLE: begin
                if (cmd_din) begin // [R12]
                    state_d = LS_CMD;
                    cnt_d   = 4'h1;
                    start_d = ~start_q;
                end
            end
            LS_CMD: begin
                sreg_d = {sreg_q[4:0], cmd_din}; // [R23]
                cnt_d  = cnt_q + 4'h1;
                if (cnt_q == `TSD_CH_DONE) begin
                    batt_d = ({sreg_q[1:0], cmd_din} == BAT_CHANNEL); // [R01]
                end
                if (cnt_q == `TSD_WORD_DONE) begin
                    word_d  = {1'b1, sreg_q[5:0], cmd_din}; // [R19]
                    wtgl_d  = ~wtgl_q;
                    state_d = LS_CONV;
                    batt_d  = 1'b0; // [R01]
                end
            end
            LS_CONV: begin
                cnt_d = cnt_q + 4'h1;
                if (cmd_din) begin
                    // Overlapped word: conversion never reports done
                    state_d = LS_CMD; // [R09]
                    cnt_d   = 4'h1;
                    start_d = ~start_q;
                end else if (cnt_q == frame_last) begin
                    state_d = LS_IDLE;
                    done_d  = ~done_q;
                end
            end
            default: begin
                state_d = LS_IDLE;
            end
        endcase
        busy_d = (state_d != LS_IDLE);
    end

    // Register the frame
    always_ff @(posedge serial_bit_clock) begin
        if (!lrst2_q) begin
            state_q <= LS_IDLE;
            cnt_q   <= 4'h0;
            sreg_q  <= 6'h00;
            word_q  <= `TSD_WORD_RST;
            start_q <= 1'b0;
            wtgl_q  <= 1'b0;
            done_q  <= 1'b0;
            batt_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sreg_q  <= sreg_d;
            word_q  <= word_d;
            start_q <= start_d;
            wtgl_q  <= wtgl_d;
            done_q  <= done_d;
            batt_q  <= batt_d;
            busy_q  <= busy_d;
        end
    end

    // ****************************************
    // Falling edge release marker
    // ****************************************
    // Nth falling edge after the start sees cnt_q equal to N
    always_comb begin
        rel_d = rel_q ^ ((state_q == LS_CMD) && (cnt_q == `TSD_REL_FALL)); // [R05]
    end

    // Register on the falling edge
    always_ff @(negedge serial_bit_clock) begin
        if (!lrst2_q) begin
            rel_q <= 1'b0;
        end else begin
            rel_q <= rel_d;
        end
    end

    assign start_tgl   = start_q;
    assign release_tgl = rel_q;
    assign word_tgl    = wtgl_q;
    assign done_tgl    = done_q;
    assign cmd_word    = word_q;
    assign batt_sample = batt_q;
    assign conv_busy   = busy_q;

endmodule
`default_nettype wire

// ### hw/tsd_pen_ctrl.sv
// Purpose: Command word decode and pen touch interrupt of a touch digitizer
// Assumes: clk at 125 MHz; serial_bit_clock from the host, unrelated phase
// Notes:   Pen pin is open drain; an outside pull-up gives the high level
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.svh"

// What this block does
// [R01] Battery divider on only while sampling battery
// [R02] Enabled pen touch pulls interrupt pin low
// [R03] Pen interrupt enabled straight after power-up
// [R04] Start bit disables pen touch detection
// [R05] Pin released at fourth falling clock edge
// [R06] Release alone never re-enables touch detection
// [R07] Pen pin idles released and high
// [R08] Touch detection stays alive while powered down
// [R09] Overlapped words keep pen interrupt disabled
// [R10] First conversion after power-up is valid
// [R11] Host starts each word with a one
// [R12] Ignore command input until start bit
// [R13] Three bits after start select channel
// [R14] Resolution bit: zero twelve, one eight
// [R15] Reference bit: one single-ended, zero differential
// [R16] Differential uses drivers, single-ended uses pin
// [R17] Host uses differential only for touch
// [R18] Host computes touch resistance from conversions
// [R19] Word layout: start, channel, res, ref, power
// [R20] New word every 15 or 11 clocks
// [R21] Pen enabled unless both power bits set
// [R22] Power bits reset to high one, low zero
// [R23] Bits shift in MSB first on rising edge
module tsd_pen_ctrl import tsd_pkg::*; #(
    parameter logic [2:0] BAT_CHANNEL = `TSD_BAT_CH
) (
    // Core clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,

    // Serial command link
    input  wire logic       serial_bit_clock,
    input  wire logic       cmd_din,

    // Panel touch comparator
    input  wire logic       touch_sense,

    // Open drain pen interrupt pin
    input  wire logic       pen_touch_irq_n_i,
    output logic            pen_touch_irq_n_o,
    output logic            pen_touch_irq_n_oe,

    // Decoded command word
    output tsd_word_t       conversion_command_word,
    output logic [2:0]      channel_select_field,
    output logic            res_8bit,
    output logic            reference_mode_bit,
    output logic            ref_from_drivers,
    output logic            power_bit_high,
    output logic            power_bit_low,

    // Analog power and switch controls
    output logic            ref_on,
    output logic            adc_on,
    output logic            batt_div_en,

    // Status
    output logic            pen_enabled,
    output logic            pen_line_level
);

    // ****************************************
    // Helpers
    // ****************************************
    // A toggle that moved between two stages marks one event
    function automatic logic tgl_event(input logic a, input logic b);
        tgl_event = a ^ b;
    endfunction

    // ****************************************
    // Link side capture
    // ****************************************
    logic      start_tgl;
    logic      release_tgl;
    logic      word_tgl;
    logic      done_tgl;
    tsd_word_t link_word;
    logic      link_batt;
    logic      link_busy;

    // Serial shifter and frame timing on the host clock
    tsd_cmd_shift #(
        .BAT_CHANNEL (BAT_CHANNEL)
    ) u_shift (
        .serial_bit_clock (serial_bit_clock),
        .rst_n            (rst_n),
        .cmd_din          (cmd_din),
        .start_tgl        (start_tgl),
        .release_tgl      (release_tgl),
        .word_tgl         (word_tgl),
        .done_tgl         (done_tgl),
        .cmd_word         (link_word),
        .batt_sample      (link_batt),
        .conv_busy        (link_busy)
    );

    // ****************************************
    // Crossing into the core clock
    // ****************************************
    // Toggle order: start, release, word, done
    logic [3:0] tgl1_q;
    logic [3:0] tgl2_q;
    logic [3:0] tgl3_q;
    // Level order: battery sample, busy, touch, pin
    logic [3:0] lvl1_q;
    logic [3:0] lvl2_q;
    logic       ev_start;
    logic       ev_release;
    logic       ev_word;
    logic       ev_done;
    logic       batt_s;
    logic       busy_s;
    logic       touch_s;
    logic       pin_s;

    // Two stages per level, three per toggle; levels use the second stage, events compare the second and third
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tgl1_q <= 4'h0;
            tgl2_q <= 4'h0;
            tgl3_q <= 4'h0;
            lvl1_q <= 4'h8;
            lvl2_q <= 4'h8;
        end else begin
            tgl1_q <= {done_tgl, word_tgl, release_tgl, start_tgl};
            tgl2_q <= tgl1_q;
            tgl3_q <= tgl2_q;
            lvl1_q <= {pen_touch_irq_n_i, touch_sense, link_busy, link_batt};
            lvl2_q <= lvl1_q;
        end
    end

    // Events and levels in the core domain
    assign ev_start   = tgl_event(tgl2_q[0], tgl3_q[0]);
    assign ev_release = tgl_event(tgl2_q[1], tgl3_q[1]);
    assign ev_word    = tgl_event(tgl2_q[2], tgl3_q[2]);
    assign ev_done    = tgl_event(tgl2_q[3], tgl3_q[3]);
    assign batt_s     = lvl2_q[0];
    assign busy_s     = lvl2_q[1];
    assign touch_s    = lvl2_q[2];
    assign pin_s      = lvl2_q[3];

    // ****************************************
    // Command word register
    // ****************************************
    tsd_word_t cmd_q, cmd_d;

    // Link word is held many link clocks, so it is stable at the event
    always_comb begin
        cmd_d = cmd_q;
        if (ev_word) begin
            cmd_d = link_word; // [R19]
        end
    end

    // Register the word; power bits come up high one, low zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= `TSD_WORD_RST; // [R22]
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // ****************************************
    // Pen interrupt control
    // ****************************************
    logic pen_en_q, pen_en_d;
    logic hold_q, hold_d;
    logic irq_low_q, irq_low_d;
    logic both_pd;

    // Both power bits set keeps everything powered and no pen detect
    assign both_pd = cmd_q[`TSD_BIT_PDH] & cmd_q[`TSD_BIT_PDL];

    // Enable, hold and pin level
    always_comb begin
        pen_en_d = pen_en_q;
        hold_d   = hold_q;
        if (ev_start) begin
            pen_en_d = 1'b0; // [R04] [R09]
            hold_d   = irq_low_q; // [R05]
        end else if (ev_done) begin
            // Re-enable only once the conversion ends
            pen_en_d = ~both_pd; // [R06] [R21] [R08]
        end
        if (ev_release) begin
            // Release does not touch the enable
            hold_d = 1'b0; // [R05] [R06]
        end
        // Touch drives the pin only while enabled; otherwise high, except a low held from the start bit until release
        irq_low_d = hold_d | (pen_en_d & touch_s); // [R02] [R07]
    end

    // Register pen state; enabled from reset on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pen_en_q  <= `TSD_PEN_RST; // [R03]
            hold_q    <= 1'b0;
            irq_low_q <= 1'b0; // [R07]
        end else begin
            pen_en_q  <= pen_en_d;
            hold_q    <= hold_d;
            irq_low_q <= irq_low_d;
        end
    end

    // ****************************************
    // Analog power and switch controls
    // ****************************************
    logic ref_on_q, ref_on_d;
    logic adc_on_q, adc_on_d;
    logic batt_q, batt_d;
    logic drv_ref_q, drv_ref_d;
    logic pin_lvl_q;

    // ADC wakes at frame start, so the first conversion is usable
    always_comb begin
        ref_on_d  = cmd_q[`TSD_BIT_PDH];
        adc_on_d  = busy_s | cmd_q[`TSD_BIT_PDL]; // [R10]
        batt_d    = batt_s; // [R01]
        drv_ref_d = ~cmd_q[`TSD_BIT_REF]; // [R15] [R16]
    end

    // Register the controls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_on_q  <= 1'b1;
            adc_on_q  <= 1'b0;
            batt_q    <= 1'b0;
            drv_ref_q <= 1'b1;
            pin_lvl_q <= 1'b1;
        end else begin
            ref_on_q  <= ref_on_d;
            adc_on_q  <= adc_on_d;
            batt_q    <= batt_d;
            drv_ref_q <= drv_ref_d;
            pin_lvl_q <= pin_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: data is always low, the enable does the work
    logic od_zero_q;

    // Constant low drive level held in a flop
    always_ff @(posedge clk) begin
        od_zero_q <= 1'b0;
    end

    assign pen_touch_irq_n_o       = od_zero_q;
    assign pen_touch_irq_n_oe      = irq_low_q; // [R02]
    assign conversion_command_word = cmd_q;
    assign channel_select_field    = cmd_q[`TSD_CH_HI:`TSD_CH_LO]; // [R13]
    assign res_8bit                = cmd_q[`TSD_BIT_RES]; // [R14]
    assign reference_mode_bit      = cmd_q[`TSD_BIT_REF]; // [R15]
    assign ref_from_drivers        = drv_ref_q;
    assign power_bit_high          = cmd_q[`TSD_BIT_PDH];
    assign power_bit_low           = cmd_q[`TSD_BIT_PDL];
    assign ref_on                  = ref_on_q;
    assign adc_on                  = adc_on_q;
    assign batt_div_en             = batt_q;
    assign pen_enabled             = pen_en_q;
    assign pen_line_level          = pin_lvl_q;

endmodule
`default_nettype wire

// ### verification/tsd_pen_ctrl_assertions.sv
// Purpose: Port-level checks of the touch digitizer pen and command logic
// Assumes: One core clock domain, sync active-low reset
// Notes:   Bound onto every tsd_pen_ctrl instance
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.svh"

module tsd_pen_ctrl_chk import tsd_pkg::*; (
    // Core clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Touch and pin
    input wire logic       touch_sense,
    input wire logic       pen_touch_irq_n_o,
    input wire logic       pen_touch_irq_n_oe,
    // Decoded word
    input wire tsd_word_t  conversion_command_word,
    input wire logic [2:0] channel_select_field,
    input wire logic       res_8bit,
    input wire logic       reference_mode_bit,
    input wire logic       ref_from_drivers,
    input wire logic       power_bit_high,
    input wire logic       power_bit_low,
    // Power and status
    input wire logic       ref_on,
    input wire logic       adc_on,
    input wire logic       batt_div_en,
    input wire logic       pen_enabled
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_vals: assert property ($rose(rst_n) |-> conversion_command_word == `TSD_WORD_RST
        && pen_enabled && ref_on && !adc_on && !batt_div_en && !pen_touch_irq_n_oe)
        else $error("reset values wrong");
    a_drain_only: assert property (pen_touch_irq_n_oe |-> pen_touch_irq_n_o == 1'b0)
        else $error("pen pin driven high");
    a_oe_needs_en: assert property ($rose(pen_touch_irq_n_oe) |->
        pen_enabled || $past(pen_enabled)) else $error("pen pin pulled while disabled");
    a_touch_pulls: assert property ((touch_sense && pen_enabled)[*5] |-> pen_touch_irq_n_oe)
        else $error("touch not reported");
    a_idle_high: assert property ((!touch_sense && pen_enabled)[*6] |-> !pen_touch_irq_n_oe)
        else $error("pen pin low without touch");
    a_pen_mode: assert property ($rose(pen_enabled) |-> !(power_bit_high && power_bit_low))
        else $error("pen enabled with both power bits set");
    a_word_fields: assert property (channel_select_field == conversion_command_word[6:4]
        && res_8bit == conversion_command_word[3] && reference_mode_bit == conversion_command_word[2]
        && {power_bit_high, power_bit_low} == conversion_command_word[1:0])
        else $error("field decode wrong");
    a_ref_source: assert property ($stable(reference_mode_bit) |->
        ref_from_drivers == !reference_mode_bit) else $error("reference source wrong");
    a_ref_power: assert property ($stable(power_bit_high) |-> ref_on == power_bit_high)
        else $error("reference power wrong");
    a_batt_short: assert property ($rose(batt_div_en) |-> ##[1:60] !batt_div_en)
        else $error("battery divider left on");
endmodule

bind tsd_pen_ctrl tsd_pen_ctrl_chk i_chk (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .touch_sense             (touch_sense),
    .pen_touch_irq_n_o       (pen_touch_irq_n_o),
    .pen_touch_irq_n_oe      (pen_touch_irq_n_oe),
    .conversion_command_word (conversion_command_word),
    .channel_select_field    (channel_select_field),
    .res_8bit                (res_8bit),
    .reference_mode_bit      (reference_mode_bit),
    .ref_from_drivers        (ref_from_drivers),
    .power_bit_high          (power_bit_high),
    .power_bit_low           (power_bit_low),
    .ref_on                  (ref_on),
    .adc_on                  (adc_on),
    .batt_div_en             (batt_div_en),
    .pen_enabled             (pen_enabled)
);
`default_nettype wire

// ### verification/tsd_host_model.sv
// Purpose: Host side of the serial command link
// Assumes: 48 ns serial clock period
// Notes:   Clock stands low between calls of send
`timescale 1ns/1ps
`default_nettype none

module tsd_host_model (
    // Serial link
    output logic serial_bit_clock,
    output logic cmd_din
);
    // ****************************************
    // Frame driver
    // ****************************************
    initial begin
        serial_bit_clock = 1'b0;
        cmd_din          = 1'b0;
    end

    // Cycles a..b-1 of a frame; data changes far from rising edges
    task automatic send(input logic [7:0] w, input int a, input int b);
        for (int i = a; i < b; i++) begin
            cmd_din = (i < 8) ? w[7-i] : 1'b0;
            #12 serial_bit_clock = 1'b1;
            #24 serial_bit_clock = 1'b0;
            #12;
        end
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench of tsd_pen_ctrl
// Assumes: Host model drives the link, pull-up on the pen pin
// Notes:   Touch held across frames to expose pin hold and release
`timescale 1ns/1ps
`default_nettype none

module tb import tsd_pkg::*;;
    logic       clk, rst_n, touch_sense, batt_seen;
    int         n_errors, checks_done, cyc;
    wire logic  serial_bit_clock, cmd_din, pen_touch_irq_n_o, pen_touch_irq_n_oe;
    wire logic  res_8bit, reference_mode_bit, ref_from_drivers, power_bit_high;
    wire logic  power_bit_low, ref_on, adc_on, batt_div_en, pen_enabled, pen_line_level;
    wire logic [2:0] channel_select_field;
    wire tsd_word_t  conversion_command_word;
    // Open drain with pull-up
    wire logic  pen_pin = pen_touch_irq_n_oe ? pen_touch_irq_n_o : 1'b1;

    tsd_host_model i_host (.serial_bit_clock(serial_bit_clock), .cmd_din(cmd_din));
    tsd_pen_ctrl i_dut (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .serial_bit_clock        (serial_bit_clock),
        .cmd_din                 (cmd_din),
        .touch_sense             (touch_sense),
        .pen_touch_irq_n_i       (pen_pin),
        .pen_touch_irq_n_o       (pen_touch_irq_n_o),
        .pen_touch_irq_n_oe      (pen_touch_irq_n_oe),
        .conversion_command_word (conversion_command_word),
        .channel_select_field    (channel_select_field),
        .res_8bit                (res_8bit),
        .reference_mode_bit      (reference_mode_bit),
        .ref_from_drivers        (ref_from_drivers),
        .power_bit_high          (power_bit_high),
        .power_bit_low           (power_bit_low),
        .ref_on                  (ref_on),
        .adc_on                  (adc_on),
        .batt_div_en             (batt_div_en),
        .pen_enabled             (pen_enabled),
        .pen_line_level          (pen_line_level)
    );

    // ****************************************
    // Clock, timeout, battery monitor
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Sampled mid-cycle, away from the edge that launches the outputs
    always @(negedge clk) begin
        cyc++;
        if (!rst_n) begin
            batt_seen <= 1'b0;
        end else if (batt_div_en === 1'b1) begin
            batt_seen <= 1'b1;
        end
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        touch_sense = 1'b0;
        // Link logic needs serial edges inside reset
        i_host.send(8'h00, 0, 3);
        tick(6);
        rst_n = 1'b1;
        tick(2);
        chk(conversion_command_word, 8'h02);
        chk(pen_enabled, 1'b1);
        chk({ref_on, adc_on, batt_div_en, ref_from_drivers}, 4'h9);
        chk({pen_touch_irq_n_oe, pen_line_level}, 2'h1);
        i_host.send(8'h00, 0, 4);
        tick(8);
        chk(conversion_command_word, 8'h02);
        touch_sense = 1'b1;
        tick(8);
        chk({pen_touch_irq_n_oe, pen_line_level}, 2'h2);
        // Word sent in pieces; the fourth falling edge closes cycle 3
        i_host.send(8'hd0, 0, 3);
        tick(8);
        chk({pen_enabled, pen_touch_irq_n_oe, adc_on}, 3'h3);
        i_host.send(8'hd0, 3, 6);
        tick(8);
        chk({pen_enabled, pen_touch_irq_n_oe}, 2'h0);
        i_host.send(8'hd0, 6, 15);
        tick(8);
        chk(conversion_command_word, 8'hd0);
        chk(channel_select_field, 3'h5);
        chk({res_8bit, reference_mode_bit, ref_from_drivers}, 3'h1);
        chk({pen_enabled, pen_touch_irq_n_oe}, 2'h3);
        // Every power setting in short frames, touch held
        for (int p = 0; p < 4; p++) begin
            i_host.send(8'hbc | p[7:0], 0, 11);
            tick(8);
            chk(conversion_command_word, 8'hbc | p[7:0]);
            chk({res_8bit, reference_mode_bit, ref_from_drivers}, 3'h6);
            chk({power_bit_high, ref_on}, {2{p[1]}});
            chk({power_bit_low, adc_on}, {2{p[0]}});
            chk({pen_enabled, pen_touch_irq_n_oe}, {2{p != 3}});
        end
        chk(batt_seen, 1'b0);
        // Battery channel, single-ended, screen released
        touch_sense = 1'b0;
        i_host.send(8'ha4, 0, 15);
        tick(8);
        chk({batt_seen, batt_div_en}, 2'h2);
        chk({pen_touch_irq_n_oe, pen_line_level, pen_enabled}, 3'h3);
        // Overlapped start lands on the cycle that would end the conversion
        i_host.send(8'h90, 0, 14);
        i_host.send(8'h90, 0, 10);
        tick(8);
        chk(pen_enabled, 1'b0);
        i_host.send(8'h90, 10, 15);
        tick(8);
        chk(pen_enabled, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
